// ==== verilog/stm_pkg.sv ====
// Constants, encodings and helper functions of the target multiphase sequencer.
package stm_pkg;

  localparam int TC_W = 24;
  localparam int DATA_W = 8;

  // Command state codes, reported through state_code.
  localparam logic [3:0] SC_RST = 4'h0;
  localparam logic [3:0] SC_SEL_OK = 4'h1;
  localparam logic [3:0] SC_ID_DONE = 4'h2;
  localparam logic [3:0] SC_CDB_START = 4'h3;
  localparam logic [3:0] SC_CDB_DONE = 4'h4;
  localparam logic [3:0] SC_DATA_START = 4'h5;
  localparam logic [3:0] SC_NO_ATN = 4'h6;
  localparam logic [3:0] SC_DATA_DONE = 4'hB;

  // Functional status bit positions.
  localparam int FI_FC = 0;
  localparam int FI_ATN = 1;
  localparam int FI_SEL = 2;
  localparam int FI_RSL = 3;
  localparam int FI_BUS_RST = 4;
  localparam int FUNCTIONAL_STATUS_REG_W = 5;
  localparam logic [4:0] FUNCTIONAL_STATUS_REG_RST = 5'h00;

  // Error status bit positions.
  localparam int EI_PE = 0;
  localparam int EI_HALT = 1;
  localparam int EI_TMO = 2;
  localparam int EI_UMS = 3;
  localparam int EI_ATN = 4;
  localparam int ERROR_STATUS_REG_W = 5;
  localparam logic [4:0] ERROR_STATUS_REG_RST = 5'h00;

  localparam logic [7:0] LUN_RST = 8'h00;
  localparam logic [1:0] ID_PREFIX = 2'h2;
  localparam int ID_BIT = 7;
  localparam logic [1:0] MSG_EARLY_BYTES = 2'h2;

  // Descriptor lengths by command group.
  localparam logic [3:0] CDB_LEN_G0 = 4'h6;
  localparam logic [3:0] CDB_LEN_G12 = 4'hA;
  localparam logic [3:0] CDB_LEN_G5 = 4'hC;

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_RESEL_SEND,
    CMD_WAIT_SEL_ATN,
    CMD_CHIP_RESET
  } stm_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RESEL,
    ST_ID_SEND,
    ST_DATA,
    ST_WAIT_SEL,
    ST_MSG_OUT,
    ST_CMD_OUT
  } stm_state_t;

  // Groups without a defined length fall back to the six-byte form.
  function automatic logic [3:0] cdb_len(input logic [2:0] grp);
    unique case (grp)
      3'h1, 3'h2: cdb_len = CDB_LEN_G12;
      3'h5: cdb_len = CDB_LEN_G5;
      default: cdb_len = CDB_LEN_G0;
    endcase
  endfunction

endpackage

// ==== verilog/stm_buf_if.sv ====
// Valid/ready carrier between the send buffer and the sequencer.
`timescale 1ns/1ps
interface stm_buf_if #(
  parameter int W = 8
);
  logic valid;
  logic [W-1:0] data;
  logic ready;
  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface

// ==== verilog/stm_buf.sv ====
// Two-entry buffer in the outgoing data path.
`timescale 1ns/1ps
module stm_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  stm_buf_if.prod out
);
  if (DEPTH != 2 || W < 1) begin : g_chk
    $error("stm_buf supports exactly two entries of nonzero width");
  end

  logic [W-1:0] d0_r;
  logic [W-1:0] d1_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'h2);
  assign out.valid = (cnt_r != 2'h0);
  assign out.data = d0_r;
  assign push = in_valid && in_ready;
  assign pop = out.valid && out.ready;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 2'h0;
    end else if (clk_en) begin
      cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
    end
  end

  // Entry 0 is always the head; a pop shifts entry 1 forward.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      d0_r <= '0;
      d1_r <= '0;
    end else if (clk_en) begin
      if (pop) begin
        d0_r <= (cnt_r == 2'h2) ? d1_r : in_data;
        if (cnt_r == 2'h2 && push) begin
          d1_r <= in_data;
        end
      end else if (push) begin
        if (cnt_r == 2'h0) begin
          d0_r <= in_data;
        end else begin
          d1_r <= in_data;
        end
      end
    end
  end
endmodule // stm_buf

// ==== verilog/stm_seq.sv ====
// Target multiphase command sequencer: reselect-and-send and wait-for-select-with-attention.
`timescale 1ns/1ps
// Operation
// - Reselect-and-send chains reselect, identify, data like the receive variant, sending data.
// - A bus reset terminates either command in any phase.
// - Chip reset command or master reset aborts any running command.
// - Failed reselection flags timeout, selected, reselected or paused.
// - Attention with halt-on-attention and nonzero count stops with attention, halt, code 5.
// - Data parity error, halt-on-parity, nonzero count sets parity and halt.
// - Data parity error at zero count sets only the parity bit.
// - Counter at zero ends data phase, code B, function complete.
// - Wait-for-select accepted disconnected or in target mode; target mode skips waiting.
// - Once selected, identify and command phases proceed without processor help.
// - No attention after selection halts with code 6.
// - Attention after selection gives code 1 and message-out without interrupt.
// - Identify byte goes to the unit register, code becomes 2.
// - Attention held after identify terminates; released attention continues to command phase.
// - Non-identify message byte goes to the FIFO and flags unexpected message.
// - Erroneous message bytes never flag unexpected message.
// - Command phase start gives code 3, all bytes received gives code 4.
// - Completion with function complete after decoded descriptor length received cleanly.
// - Parity error on first descriptor byte halts too; later bytes only parity.
// - Message parity error beyond two bytes: parity bit, code 1; earlier bytes halt too.
// - Reselected or paused while waiting leaves code 0 with its flag.
// - Any deviation terminates; code shows last successful phase.
// - Identify byte sent is binary 10 followed by unit field bits 5 to 0.
module stm_seq #(
  parameter int TC_W = stm_pkg::TC_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire stm_pkg::stm_cmd_t cmd_code,
  input wire logic [TC_W-1:0] tc_load,
  input wire logic halt_on_attention_enable,
  input wire logic halt_on_parity_enable,
  input wire logic target_mode,
  input wire logic status_clear,
  input wire logic master_reset_input,
  input wire logic atn_pin,
  input wire logic bus_reset_evt,
  input wire logic resel_ok,
  input wire logic resel_timeout,
  input wire logic sel_as_target,
  input wire logic resel_as_init,
  input wire logic pause_evt,
  input wire logic selected_evt,
  input wire logic src_valid,
  input wire logic [7:0] src_data,
  output logic src_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic tx_parity_err,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity_err,
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,
  output logic [7:0] logical_unit_field,
  output logic [TC_W-1:0] transfer_counter,
  output logic [3:0] state_code,
  output logic [stm_pkg::FUNCTIONAL_STATUS_REG_W-1:0] functional_status_reg,
  output logic [stm_pkg::ERROR_STATUS_REG_W-1:0] error_status_reg,
  output logic busy
);
  if (TC_W < 1) begin : g_chk
    $error("stm_seq needs a transfer counter of at least one bit");
  end

  stm_buf_if #(.W(8)) txb ();

  stm_buf #(.W(8), .DEPTH(2)) u_buf (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_valid(src_valid),
    .in_data(src_data),
    .in_ready(src_ready),
    .out(txb)
  );

  stm_pkg::stm_state_t state_r, state_nxt;
  logic [3:0] code_r, code_nxt;
  logic [TC_W-1:0] tc_r, tc_nxt;
  logic [1:0] mcnt_r, mcnt_nxt;
  logic [3:0] ccnt_r, ccnt_nxt;
  logic [3:0] clen_r, clen_nxt;
  logic [7:0] lun_r, lun_nxt;
  logic [stm_pkg::FUNCTIONAL_STATUS_REG_W-1:0] functional_status_reg_r, fset;
  logic [stm_pkg::ERROR_STATUS_REG_W-1:0] error_status_reg_r, eset;
  logic rxo_v_r, rxo_v_nxt;
  logic [7:0] rxo_d_r, rxo_d_nxt;
  logic mr_m_r, mr_s_r, atn_m_r, atn_s_r;
  logic chip_rst;
  logic [3:0] cur_len;
  logic [7:0] id_byte;

  // Both pins are asynchronous to clk_sys.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mr_m_r <= 1'b0;
      mr_s_r <= 1'b0;
      atn_m_r <= 1'b0;
      atn_s_r <= 1'b0;
    end else if (clk_en) begin
      mr_m_r <= master_reset_input;
      mr_s_r <= mr_m_r;
      atn_m_r <= atn_pin;
      atn_s_r <= atn_m_r;
    end
  end

  assign chip_rst = mr_s_r || (cmd_valid && cmd_code == stm_pkg::CMD_CHIP_RESET);
  assign id_byte = {stm_pkg::ID_PREFIX, lun_r[5:0]};
  assign tx_valid = (state_r == stm_pkg::ST_ID_SEND) ||
                    (state_r == stm_pkg::ST_DATA && txb.valid && tc_r != '0);
  assign tx_data = (state_r == stm_pkg::ST_ID_SEND) ? id_byte : txb.data;
  assign txb.ready = (state_r == stm_pkg::ST_DATA) && (tc_r != '0) && tx_ready;
  assign cur_len = (ccnt_r == 4'h0) ? stm_pkg::cdb_len(rx_data[7:5]) : clen_r;

  always_comb begin
    state_nxt = state_r;
    code_nxt = code_r;
    tc_nxt = tc_r;
    mcnt_nxt = mcnt_r;
    ccnt_nxt = ccnt_r;
    clen_nxt = clen_r;
    lun_nxt = lun_r;
    rxo_v_nxt = 1'b0;
    rxo_d_nxt = rxo_d_r;
    fset = '0;
    eset = '0;
    if (bus_reset_evt && state_r != stm_pkg::ST_IDLE) begin
      fset[stm_pkg::FI_BUS_RST] = 1'b1;
      state_nxt = stm_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        stm_pkg::ST_IDLE: begin
          if (cmd_valid && cmd_code == stm_pkg::CMD_RESEL_SEND) begin
            state_nxt = stm_pkg::ST_RESEL;
            code_nxt = stm_pkg::SC_RST;
            tc_nxt = tc_load;
          end else if (cmd_valid && cmd_code == stm_pkg::CMD_WAIT_SEL_ATN) begin
            state_nxt = stm_pkg::ST_WAIT_SEL;
            code_nxt = stm_pkg::SC_RST;
            mcnt_nxt = 2'h0;
          end
        end
        stm_pkg::ST_RESEL: begin
          if (resel_ok) begin
            code_nxt = stm_pkg::SC_SEL_OK;
            if (atn_s_r) begin
              fset[stm_pkg::FI_ATN] = 1'b1;
              state_nxt = stm_pkg::ST_IDLE;
            end else begin
              state_nxt = stm_pkg::ST_ID_SEND;
            end
          end else if (resel_timeout || sel_as_target || resel_as_init || pause_evt) begin
            eset[stm_pkg::EI_TMO] = resel_timeout;
            fset[stm_pkg::FI_SEL] = sel_as_target;
            fset[stm_pkg::FI_RSL] = resel_as_init;
            eset[stm_pkg::EI_HALT] = pause_evt;
            state_nxt = stm_pkg::ST_IDLE;
          end
        end
        stm_pkg::ST_ID_SEND: begin
          if (tx_ready) begin
            code_nxt = stm_pkg::SC_ID_DONE;
            if (atn_s_r) begin
              fset[stm_pkg::FI_ATN] = 1'b1;
              state_nxt = stm_pkg::ST_IDLE;
            end else begin
              code_nxt = stm_pkg::SC_DATA_START;
              state_nxt = stm_pkg::ST_DATA;
            end
          end
        end
        stm_pkg::ST_DATA: begin
          if (tc_r == '0) begin
            eset[stm_pkg::EI_PE] = tx_parity_err;
            fset[stm_pkg::FI_FC] = 1'b1;
            code_nxt = stm_pkg::SC_DATA_DONE;
            state_nxt = stm_pkg::ST_IDLE;
          end else if (atn_s_r && halt_on_attention_enable) begin
            fset[stm_pkg::FI_ATN] = 1'b1;
            eset[stm_pkg::EI_HALT] = 1'b1;
            state_nxt = stm_pkg::ST_IDLE;
          end else if (tx_parity_err && halt_on_parity_enable) begin
            eset[stm_pkg::EI_PE] = 1'b1;
            eset[stm_pkg::EI_HALT] = 1'b1;
            state_nxt = stm_pkg::ST_IDLE;
          end else begin
            eset[stm_pkg::EI_PE] = tx_parity_err;
            if (txb.valid && tx_ready) begin
              tc_nxt = TC_W'(tc_r - 1'b1);
            end
          end
        end
        stm_pkg::ST_WAIT_SEL: begin
          // Already in target mode there is nothing to wait for.
          if (target_mode || selected_evt) begin
            if (!atn_s_r) begin
              code_nxt = stm_pkg::SC_NO_ATN;
              eset[stm_pkg::EI_HALT] = 1'b1;
              state_nxt = stm_pkg::ST_IDLE;
            end else begin
              code_nxt = stm_pkg::SC_SEL_OK;
              state_nxt = stm_pkg::ST_MSG_OUT;
            end
          end else if (resel_as_init || pause_evt) begin
            fset[stm_pkg::FI_RSL] = resel_as_init;
            eset[stm_pkg::EI_HALT] = pause_evt;
            state_nxt = stm_pkg::ST_IDLE;
          end
        end
        stm_pkg::ST_MSG_OUT: begin
          if (rx_valid) begin
            if (mcnt_r != 2'h3) begin
              mcnt_nxt = 2'(mcnt_r + 2'h1);
            end
            if (rx_parity_err) begin
              // A damaged byte is never classed as an unexpected message.
              eset[stm_pkg::EI_PE] = 1'b1;
              eset[stm_pkg::EI_HALT] = (mcnt_r < stm_pkg::MSG_EARLY_BYTES);
              state_nxt = stm_pkg::ST_IDLE;
            end else if (rx_data[stm_pkg::ID_BIT]) begin
              lun_nxt = rx_data;
              code_nxt = stm_pkg::SC_ID_DONE;
              if (atn_s_r) begin
                eset[stm_pkg::EI_ATN] = 1'b1;
                state_nxt = stm_pkg::ST_IDLE;
              end else begin
                code_nxt = stm_pkg::SC_CDB_START;
                ccnt_nxt = 4'h0;
                state_nxt = stm_pkg::ST_CMD_OUT;
              end
            end else begin
              rxo_v_nxt = 1'b1;
              rxo_d_nxt = rx_data;
              eset[stm_pkg::EI_UMS] = 1'b1;
              state_nxt = stm_pkg::ST_IDLE;
            end
          end
        end
        stm_pkg::ST_CMD_OUT: begin
          if (rx_valid) begin
            if (rx_parity_err) begin
              eset[stm_pkg::EI_PE] = 1'b1;
              eset[stm_pkg::EI_HALT] = (ccnt_r == 4'h0);
              state_nxt = stm_pkg::ST_IDLE;
            end else begin
              rxo_v_nxt = 1'b1;
              rxo_d_nxt = rx_data;
              clen_nxt = cur_len;
              ccnt_nxt = 4'(ccnt_r + 4'h1);
              if (4'(ccnt_r + 4'h1) == cur_len) begin
                code_nxt = stm_pkg::SC_CDB_DONE;
                fset[stm_pkg::FI_FC] = 1'b1;
                state_nxt = stm_pkg::ST_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  // On termination the code keeps the last successful phase until a new command or a master reset.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= stm_pkg::ST_IDLE;
      code_r <= stm_pkg::SC_RST;
    end else if (clk_en) begin
      if (chip_rst) begin
        state_r <= stm_pkg::ST_IDLE;
        code_r <= stm_pkg::SC_RST;
      end else begin
        state_r <= state_nxt;
        code_r <= code_nxt;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tc_r <= '0;
      mcnt_r <= 2'h0;
      ccnt_r <= 4'h0;
      clen_r <= stm_pkg::CDB_LEN_G0;
      lun_r <= stm_pkg::LUN_RST;
    end else if (clk_en) begin
      tc_r <= tc_nxt;
      mcnt_r <= mcnt_nxt;
      ccnt_r <= ccnt_nxt;
      clen_r <= clen_nxt;
      lun_r <= lun_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rxo_v_r <= 1'b0;
      rxo_d_r <= '0;
    end else if (clk_en) begin
      rxo_v_r <= rxo_v_nxt && !chip_rst;
      rxo_d_r <= rxo_d_nxt;
    end
  end

  // A flag raised in the cycle of a clear survives the clear.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      functional_status_reg_r <= stm_pkg::FUNCTIONAL_STATUS_REG_RST;
      error_status_reg_r <= stm_pkg::ERROR_STATUS_REG_RST;
    end else if (clk_en) begin
      if (chip_rst) begin
        functional_status_reg_r <= stm_pkg::FUNCTIONAL_STATUS_REG_RST;
        error_status_reg_r <= stm_pkg::ERROR_STATUS_REG_RST;
      end else begin
        functional_status_reg_r <= (functional_status_reg_r & ~{stm_pkg::FUNCTIONAL_STATUS_REG_W{status_clear}}) | fset;
        error_status_reg_r <= (error_status_reg_r & ~{stm_pkg::ERROR_STATUS_REG_W{status_clear}}) | eset;
      end
    end
  end

  assign rx_out_valid = rxo_v_r;
  assign rx_out_data = rxo_d_r;
  assign logical_unit_field = lun_r;
  assign transfer_counter = tc_r;
  assign state_code = code_r;
  assign functional_status_reg = functional_status_reg_r;
  assign error_status_reg = error_status_reg_r;
  assign busy = (state_r != stm_pkg::ST_IDLE);

  a_id_byte_form: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == stm_pkg::ST_ID_SEND) |-> (tx_valid && tx_data == {2'h2, lun_r[5:0]}))
    else $error("identify byte malformed");

  a_no_atn_halt: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && state_r == stm_pkg::ST_WAIT_SEL && selected_evt && !atn_s_r &&
     !bus_reset_evt && !chip_rst) |=> (state_r == stm_pkg::ST_IDLE && code_r == 4'h6 &&
     error_status_reg_r[stm_pkg::EI_HALT]))
    else $error("missing halt with code 6");

  a_atn_msg_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && state_r == stm_pkg::ST_WAIT_SEL && selected_evt && atn_s_r &&
     !bus_reset_evt && !chip_rst) |=> (state_r == stm_pkg::ST_MSG_OUT && code_r == 4'h1))
    else $error("selection with attention did not enter message-out");

  a_tc_zero_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && state_r == stm_pkg::ST_DATA && tc_r == '0 && !bus_reset_evt && !chip_rst)
    |=> (state_r == stm_pkg::ST_IDLE && code_r == 4'hB && functional_status_reg_r[stm_pkg::FI_FC]))
    else $error("zero count did not complete data phase");

  a_atn_halt_data: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && state_r == stm_pkg::ST_DATA && tc_r != '0 && atn_s_r &&
     halt_on_attention_enable && !bus_reset_evt && !chip_rst) |=>
    (functional_status_reg_r[stm_pkg::FI_ATN] && error_status_reg_r[stm_pkg::EI_HALT] && code_r == 4'h5))
    else $error("attention halt in data phase wrong");

  a_mr_abort: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && mr_s_r) |=> (state_r == stm_pkg::ST_IDLE && !busy))
    else $error("master reset did not abort");

  a_bus_rst_any: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && bus_reset_evt && busy && !chip_rst) |=>
    (!busy && functional_status_reg_r[stm_pkg::FI_BUS_RST]))
    else $error("bus reset did not terminate command");

  a_code_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!busy && !(clk_en && (cmd_valid || mr_s_r))) |=> $stable(code_r))
    else $error("state code changed while idle");

  a_resel_tmo: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clk_en && state_r == stm_pkg::ST_RESEL && !resel_ok && resel_timeout &&
     !bus_reset_evt && !chip_rst) |=> (error_status_reg_r[stm_pkg::EI_TMO] && code_r == 4'h0 && !busy))
    else $error("reselect timeout not reported");
endmodule // stm_seq

// ==== test/stm_init_model.sv ====
// Behavioural initiator facing the target sequencer.
`timescale 1ns/1ps
module stm_init_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic atn_pin,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_parity_err
);
  logic [7:0] got_q[$];
  initial begin
    tx_ready = 1'b0;
    atn_pin = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_parity_err = 1'b0;
  end
  // Random stalls keep back-pressure on the two-entry buffer.
  always @(negedge clk_sys) tx_ready <= ($urandom % 3) != 0;
  always @(posedge clk_sys) begin
    if (!sys_rst && tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
    end
  end
  // A released data line shows the inverse so a stale byte is never mistaken for a new one.
  task automatic put_byte(input logic [7:0] b, input logic pe);
    @(negedge clk_sys);
    rx_valid = 1'b1;
    rx_data = b;
    rx_parity_err = pe;
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_data = ~b;
    rx_parity_err = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  // The line is synchronised inside the device, so it is given time to settle.
  task automatic drive_atn(input logic v);
    atn_pin = v;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule // stm_init_model

// ==== test/tb_top.sv ====
// Self-checking bench of the target multiphase sequencer.
`timescale 1ns/1ps
module tb_top;
  localparam int E_BR = 0, E_OK = 1, E_TMO = 2, E_SLT = 3, E_RSL = 4, E_PAU = 5, E_SEL = 6;
  localparam int E_TPE = 7;
  logic clk_sys, sys_rst, cmd_valid, status_clear, master_reset_input, target_mode;
  logic halt_on_attention_enable, halt_on_parity_enable, src_valid, src_ready;
  logic tx_valid, tx_ready, atn_pin, rx_valid, rx_parity_err, rx_out_valid, busy;
  logic clk_en, bus_reset_evt, resel_ok, resel_timeout, sel_as_target, resel_as_init;
  logic pause_evt, selected_evt, tx_parity_err;
  logic [7:0] ev, src_data, tx_data, rx_data, rx_out_data, logical_unit_field, lun, last_rx;
  logic [23:0] tc_load, transfer_counter;
  logic [3:0] state_code;
  logic [4:0] functional_status_reg, error_status_reg;
  stm_pkg::stm_cmd_t cmd_code;
  logic [7:0] src_q[$], exp_q[$];
  int err_count, n_compared, n_rx, k, n;
  int grps[4] = '{0, 1, 5, 6};
  int fl_ev[6] = '{E_TMO, E_SLT, E_RSL, E_PAU, E_RSL, E_PAU};
  assign {tx_parity_err, selected_evt, pause_evt, resel_as_init, sel_as_target,
          resel_timeout, resel_ok, bus_reset_evt} = ev;
  stm_seq dut (
    .clk_sys, .sys_rst, .clk_en, .cmd_valid, .cmd_code, .tc_load,
    .halt_on_attention_enable, .halt_on_parity_enable, .target_mode, .status_clear,
    .master_reset_input, .atn_pin, .bus_reset_evt, .resel_ok, .resel_timeout,
    .sel_as_target, .resel_as_init, .pause_evt, .selected_evt, .src_valid, .src_data,
    .src_ready, .tx_valid, .tx_data, .tx_ready, .tx_parity_err, .rx_valid, .rx_data,
    .rx_parity_err, .rx_out_valid, .rx_out_data, .logical_unit_field, .transfer_counter,
    .state_code, .functional_status_reg, .error_status_reg, .busy
  );
  stm_init_model init (
    .clk_sys, .sys_rst, .tx_valid, .tx_data, .tx_ready, .atn_pin, .rx_valid, .rx_data,
    .rx_parity_err
  );
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rx_out_valid === 1'b1) begin
      n_rx++;
      last_rx = rx_out_data;
    end
    if (src_valid && src_ready) void'(src_q.pop_front());
  end
  always @(negedge clk_sys) begin
    src_valid <= src_q.size() != 0;
    src_data <= src_q.size() != 0 ? src_q[0] : ~src_data;
  end
  function automatic logic [4:0] bt(input int p);
    return 5'h01 << p;
  endfunction
  function automatic int cdb_bytes(input int grp);
    if (grp == 1 || grp == 2) return 10;
    if (grp == 5) return 12;
    return 6;
  endfunction
  function automatic logic [9:0] fail_flags(input int i);
    case (i)
      0: return {5'h00, bt(stm_pkg::EI_TMO)};
      1: return {bt(stm_pkg::FI_SEL), 5'h00};
      2, 4: return {bt(stm_pkg::FI_RSL), 5'h00};
      6: return {5'h00, bt(stm_pkg::EI_UMS)};
      7, 9, 12: return {5'h00, bt(stm_pkg::EI_PE) | bt(stm_pkg::EI_HALT)};
      8: return {5'h00, bt(stm_pkg::EI_ATN)};
      10: return {5'h00, bt(stm_pkg::EI_PE)};
      11: return {bt(stm_pkg::FI_ATN), bt(stm_pkg::EI_HALT)};
      13: return {bt(stm_pkg::FI_BUS_RST), 5'h00};
      default: return {5'h00, bt(stm_pkg::EI_HALT)};
    endcase
  endfunction
  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_on(input logic idle, input logic [3:0] c);
    int i;
    for (i = 0; i < 3000; i++) begin
      if (idle ? busy === 1'b0 : state_code === c) break;
      @(negedge clk_sys);
    end
    if (i == 3000) begin
      err_count++;
      report_and_stop();
    end
  endtask
  task automatic ends(input logic [3:0] c, input logic [9:0] fe);
    wait_on(1'b1, 4'h0);
    chk("state_code", 24'(c), 24'(state_code));
    chk("status", 24'(fe), 24'({functional_status_reg, error_status_reg}));
  endtask
  task automatic issue(input stm_pkg::stm_cmd_t c);
    @(negedge clk_sys);
    status_clear = 1'b1;
    @(negedge clk_sys);
    status_clear = 1'b0;
    cmd_valid = 1'b1;
    cmd_code = c;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_code = stm_pkg::CMD_NONE;
  endtask
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    @(negedge clk_sys);
    ev[i] = 1'b0;
  endtask
  task automatic enter_cdb(input logic [7:0] id);
    init.drive_atn(1'b1);
    issue(stm_pkg::CMD_WAIT_SEL_ATN);
    pulse(E_SEL);
    wait_on(1'b0, 4'h1);
    chk("busy", 24'h1, 24'(busy));
    init.drive_atn(1'b0);
    n_rx = 0;
    init.put_byte(id, 1'b0);
    chk("unit", 24'(id), 24'(logical_unit_field));
    chk("code", 24'h3, 24'(state_code));
  endtask
  initial begin
    void'($urandom(8));
    {cmd_valid, status_clear, master_reset_input, target_mode, src_valid} = 5'h00;
    {halt_on_attention_enable, halt_on_parity_enable} = 2'h0;
    {ev, src_data, tc_load} = 40'h0;
    cmd_code = stm_pkg::CMD_NONE;
    clk_en = 1'b1;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk("rst", 24'h0, 24'({busy, state_code, functional_status_reg, error_status_reg}));
    foreach (grps[j]) begin
      lun = {1'b1, 7'($urandom)};
      enter_cdb(lun);
      for (k = 0; k < cdb_bytes(grps[j]); k++) begin
        init.put_byte(k == 0 ? {3'(grps[j]), 5'($urandom)} : 8'($urandom), 1'b0);
      end
      ends(4'h4, {bt(stm_pkg::FI_FC), 5'h00});
      chk("cdb", 24'(cdb_bytes(grps[j])), 24'(n_rx));
    end
    n = 3 + $urandom % 6;
    tc_load = 24'(n);
    for (k = 0; k < n; k++) src_q.push_back(8'($urandom));
    exp_q = src_q;
    repeat (4) @(negedge clk_sys);
    chk("src_ready", 24'h0, 24'(src_ready));
    init.got_q.delete();
    issue(stm_pkg::CMD_RESEL_SEND);
    pulse(E_OK);
    ends(4'hB, {bt(stm_pkg::FI_FC), 5'h00});
    repeat (5) @(negedge clk_sys);
    chk("held", 24'hB, 24'(state_code));
    chk("count", 24'h0, 24'(transfer_counter));
    chk("sent", 24'(n + 1), 24'(init.got_q.size()));
    chk("id", 24'({2'h2, lun[5:0]}), 24'(init.got_q[0]));
    for (k = 0; k < n; k++) chk("data", 24'(exp_q[k]), 24'(init.got_q[k + 1]));
    for (k = 0; k < 6; k++) begin
      issue(k < 4 ? stm_pkg::CMD_RESEL_SEND : stm_pkg::CMD_WAIT_SEL_ATN);
      pulse(fl_ev[k]);
      ends(4'h0, fail_flags(k));
    end
    // A selection seen while the clock enable is low must leave the wait untouched.
    issue(stm_pkg::CMD_WAIT_SEL_ATN);
    clk_en = 1'b0;
    pulse(E_SEL);
    @(negedge clk_sys);
    clk_en = 1'b1;
    chk("frozen", 24'h10, 24'({busy, state_code}));
    pulse(E_PAU);
    ends(4'h0, fail_flags(5));
    issue(stm_pkg::CMD_WAIT_SEL_ATN);
    pulse(E_SEL);
    ends(4'h6, fail_flags(3));
    init.drive_atn(1'b1);
    for (k = 0; k < 3; k++) begin
      issue(stm_pkg::CMD_WAIT_SEL_ATN);
      pulse(E_SEL);
      n_rx = 0;
      lun = k == 0 ? {1'b0, 7'($urandom)} : 8'h80;
      init.put_byte(lun, k == 1);
      ends(k == 2 ? 4'h2 : 4'h1, fail_flags(k + 6));
      if (k != 1) chk("fifo", 24'(k == 0), 24'(n_rx));
      if (k == 0) chk("fifo_data", 24'(lun), 24'(last_rx));
    end
    for (k = 0; k < 2; k++) begin
      enter_cdb(8'h80);
      if (k == 1) init.put_byte(8'h00, 1'b0);
      init.put_byte(8'h00, 1'b1);
      ends(4'h3, fail_flags(k + 9));
    end
    {halt_on_attention_enable, halt_on_parity_enable} = 2'h3;
    tc_load = 24'h000040;
    for (k = 0; k < 3; k++) begin
      issue(stm_pkg::CMD_RESEL_SEND);
      pulse(E_OK);
      wait_on(1'b0, 4'h5);
      if (k == 0) init.drive_atn(1'b1);
      else pulse(k == 1 ? E_TPE : E_BR);
      ends(4'h5, fail_flags(k + 11));
      chk("count", 24'h40, 24'(transfer_counter));
      init.drive_atn(1'b0);
    end
    // A parity error standing when the count is already zero only flags parity.
    tc_load = 24'h000000;
    ev[E_TPE] = 1'b1;
    issue(stm_pkg::CMD_RESEL_SEND);
    pulse(E_OK);
    ends(4'hB, {bt(stm_pkg::FI_FC), bt(stm_pkg::EI_PE)});
    ev[E_TPE] = 1'b0;
    target_mode = 1'b1;
    init.drive_atn(1'b1);
    issue(stm_pkg::CMD_WAIT_SEL_ATN);
    wait_on(1'b0, 4'h1);
    issue(stm_pkg::CMD_CHIP_RESET);
    ends(4'h0, 10'h000);
    target_mode = 1'b0;
    issue(stm_pkg::CMD_WAIT_SEL_ATN);
    master_reset_input = 1'b1;
    repeat (4) @(negedge clk_sys);
    master_reset_input = 1'b0;
    ends(4'h0, 10'h000);
    report_and_stop();
  end
endmodule // tb_top
